// ### verilog/status_word_pkg.sv
// Constants and carriers for the program status word block
// Contract
// - Nibble carry is set by a carry into or borrow from the high nibble.
// - Arithmetic with no nibble carry or borrow clears that flag.
// - Bits 5 and 1 are software flags that no hardware operation alters.
// - Bits 4 and 3 select the bank at 0x00, 0x08, 0x10 or 0x18.
// - Carry flag at bit 7 is set by an add carry or subtract borrow.
// - Overflowing mul or div sets overflow; other arithmetic clears it.
package status_word_pkg;

	localparam logic [7:0] STATUS_WORD_ADDR  = 8'hd0;
	localparam logic [7:0] STATUS_WORD_RESET = 8'h00;
	localparam int         CARRY_BIT         = 7;
	localparam int         NIBBLE_BIT        = 6;
	localparam int         USER_A_BIT        = 5;
	localparam int         BANK_HI_BIT       = 4;
	localparam int         BANK_LO_BIT       = 3;
	localparam int         OVERFLOW_BIT      = 2;
	localparam int         USER_B_BIT        = 1;
	localparam int         PARITY_BIT        = 0;
	localparam int         BANK_SHIFT        = 3;
	localparam logic [7:0] BANK_SIZE         = 8'h08;

	// Flag update request from the ALU, one-cycle pulse when valid
	typedef struct packed {
		logic valid;
		logic carry;
		logic nibble_carry;
		logic overflow;
	} alu_flags_s;

	// Software access to the special function register space
	typedef struct packed {
		logic       wr_en;
		logic       bit_wr_en;
		logic [7:0] addr;
		logic [2:0] bit_sel;
		logic [7:0] wdata;
		logic       bit_value;
	} sfr_req_s;

	typedef struct packed {
		logic [7:0] word;
		logic [7:0] rdata;
		logic [7:0] bank_base;
	} state_s;

endpackage

// ### verilog/program_status_word_flags.sv
// Program status word with ALU flag update and bank select
`timescale 1ns/1ps
module program_status_word_flags (
	input  wire logic                       clk_sys_i,
	input  wire logic                       rst_n_i,
	input  wire status_word_pkg::alu_flags_s alu_flags_i,
	input  wire status_word_pkg::sfr_req_s   sfr_req_i,
	input  wire logic [7:0]                  accumulator_i,
	output logic [7:0]                       status_word_o,
	output logic [7:0]                       sfr_rdata_o,
	output logic                             carry_flag_o,
	output logic                             nibble_carry_flag_o,
	output logic                             overflow_flag_o,
	output logic [1:0]                       bank_select_o,
	output logic [7:0]                       bank_base_o
);

	status_word_pkg::state_s state_reg;
	status_word_pkg::state_s state_next;

	function automatic logic [7:0] bank_base(input logic [1:0] sel);
		bank_base = 8'(sel) * status_word_pkg::BANK_SIZE;
	endfunction

	function automatic logic [1:0] bank_of(input logic [7:0] w);
		bank_of = {w[status_word_pkg::BANK_HI_BIT],
			w[status_word_pkg::BANK_LO_BIT]};
	endfunction

	logic hit;
	logic sw_write;
	assign hit      = sfr_req_i.addr == status_word_pkg::STATUS_WORD_ADDR;
	assign sw_write = hit && (sfr_req_i.wr_en || sfr_req_i.bit_wr_en);

	// Byte write replaces the word; a bit write touches one position
	function automatic logic [7:0] sw_merge(
		input logic [7:0]                w,
		input status_word_pkg::sfr_req_s req
	);
		sw_merge = w;
		if (req.wr_en) begin
			sw_merge = req.wdata;
		end else if (req.bit_wr_en) begin
			sw_merge[req.bit_sel] = req.bit_value;
		end
	endfunction

	// Only the three arithmetic flags follow the ALU
	function automatic logic [7:0] alu_merge(
		input logic [7:0]                  w,
		input status_word_pkg::alu_flags_s f
	);
		alu_merge = w;
		alu_merge[status_word_pkg::CARRY_BIT]    = f.carry;
		alu_merge[status_word_pkg::NIBBLE_BIT]   = f.nibble_carry;
		alu_merge[status_word_pkg::OVERFLOW_BIT] = f.overflow;
	endfunction

	always_comb begin
		logic [7:0] w;
		w = state_reg.word;
		// Software goes first so a same-cycle ALU update wins its flags
		if (hit) begin
			w = sw_merge(w, sfr_req_i);
		end
		if (alu_flags_i.valid) begin
			w = alu_merge(w, alu_flags_i);
		end
		// Read-only parity overrides any write to bit 0
		w[status_word_pkg::PARITY_BIT] = ^accumulator_i;
		state_next.word      = w;
		state_next.rdata     = w;
		state_next.bank_base = bank_base(bank_of(w));
	end

	always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_reg.word      <= status_word_pkg::STATUS_WORD_RESET;
			state_reg.rdata     <= status_word_pkg::STATUS_WORD_RESET;
			state_reg.bank_base <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	always_comb begin
		status_word_o       = state_reg.word;
		sfr_rdata_o         = state_reg.rdata;
		carry_flag_o        = state_reg.word[status_word_pkg::CARRY_BIT];
		nibble_carry_flag_o = state_reg.word[status_word_pkg::NIBBLE_BIT];
		overflow_flag_o     = state_reg.word[status_word_pkg::OVERFLOW_BIT];
		bank_select_o       = bank_of(state_reg.word);
		bank_base_o         = state_reg.bank_base;
	end

	nibble_flag_a: assert property (@(posedge clk_sys_i)
		disable iff (!rst_n_i)
		alu_flags_i.valid |=>
		nibble_carry_flag_o == $past(alu_flags_i.nibble_carry))
		else $error("nibble carry flag mismatch");

	nibble_set_a: assert property (@(posedge clk_sys_i)
		disable iff (!rst_n_i)
		alu_flags_i.valid && alu_flags_i.nibble_carry |=>
		nibble_carry_flag_o)
		else $error("nibble carry not set");

	nibble_hold_a: assert property (@(posedge clk_sys_i)
		disable iff (!rst_n_i)
		!alu_flags_i.valid && !sw_write |=>
		$stable(nibble_carry_flag_o))
		else $error("nibble carry changed without cause");

	nibble_clear_a: assert property (@(posedge clk_sys_i)
		disable iff (!rst_n_i)
		alu_flags_i.valid && !alu_flags_i.nibble_carry |=>
		!nibble_carry_flag_o)
		else $error("nibble carry not cleared");

	user_flags_a: assert property (@(posedge clk_sys_i)
		disable iff (!rst_n_i)
		!sw_write |=>
		$stable({status_word_o[status_word_pkg::USER_A_BIT],
			status_word_o[status_word_pkg::USER_B_BIT]}))
		else $error("user flag changed by hardware");

	user_byte_a: assert property (@(posedge clk_sys_i)
		disable iff (!rst_n_i)
		hit && sfr_req_i.wr_en |=>
		status_word_o[status_word_pkg::USER_A_BIT] ==
		$past(sfr_req_i.wdata[status_word_pkg::USER_A_BIT]) &&
		status_word_o[status_word_pkg::USER_B_BIT] ==
		$past(sfr_req_i.wdata[status_word_pkg::USER_B_BIT]))
		else $error("user flags not taken from byte write");

	user_a_write_a: assert property (@(posedge clk_sys_i)
		disable iff (!rst_n_i)
		sw_write && !sfr_req_i.wr_en &&
		sfr_req_i.bit_sel == 3'(status_word_pkg::USER_A_BIT) |=>
		status_word_o[status_word_pkg::USER_A_BIT] ==
		$past(sfr_req_i.bit_value))
		else $error("user flag a bit write lost");

	user_b_write_a: assert property (@(posedge clk_sys_i)
		disable iff (!rst_n_i)
		sw_write && !sfr_req_i.wr_en &&
		sfr_req_i.bit_sel == 3'(status_word_pkg::USER_B_BIT) |=>
		status_word_o[status_word_pkg::USER_B_BIT] ==
		$past(sfr_req_i.bit_value))
		else $error("user flag b bit write lost");

	rdata_word_a: assert property (@(posedge clk_sys_i)
		disable iff (!rst_n_i)
		1'b1 |->
		sfr_rdata_o == status_word_o)
		else $error("read data differs from word");

	bank_base_a: assert property (@(posedge clk_sys_i)
		disable iff (!rst_n_i)
		1'b1 |->
		bank_base_o == 8'(bank_select_o) << status_word_pkg::BANK_SHIFT)
		else $error("bank base mismatch");

	bank_write_a: assert property (@(posedge clk_sys_i)
		disable iff (!rst_n_i)
		hit && sfr_req_i.wr_en |=>
		bank_select_o ==
		$past({sfr_req_i.wdata[status_word_pkg::BANK_HI_BIT],
			sfr_req_i.wdata[status_word_pkg::BANK_LO_BIT]}))
		else $error("bank select not taken from byte write");

	bank_hold_a: assert property (@(posedge clk_sys_i)
		disable iff (!rst_n_i)
		!sw_write |=>
		$stable(bank_select_o))
		else $error("bank select changed by hardware");

	overflow_set_a: assert property (@(posedge clk_sys_i)
		disable iff (!rst_n_i)
		alu_flags_i.valid && alu_flags_i.overflow |=>
		overflow_flag_o)
		else $error("overflow not set");

	overflow_flag_a: assert property (@(posedge clk_sys_i)
		disable iff (!rst_n_i)
		alu_flags_i.valid |=>
		overflow_flag_o == $past(alu_flags_i.overflow))
		else $error("overflow flag mismatch");

	overflow_clr_a: assert property (@(posedge clk_sys_i)
		disable iff (!rst_n_i)
		alu_flags_i.valid && !alu_flags_i.overflow |=>
		!overflow_flag_o)
		else $error("overflow not cleared");

	overflow_hold_a: assert property (@(posedge clk_sys_i)
		disable iff (!rst_n_i)
		!alu_flags_i.valid && !sw_write |=>
		$stable(overflow_flag_o))
		else $error("overflow changed without cause");

	carry_flag_a: assert property (@(posedge clk_sys_i)
		disable iff (!rst_n_i)
		alu_flags_i.valid |=>
		carry_flag_o == $past(alu_flags_i.carry))
		else $error("carry flag mismatch");

	carry_hold_a: assert property (@(posedge clk_sys_i)
		disable iff (!rst_n_i)
		!alu_flags_i.valid && !sw_write |=>
		$stable(carry_flag_o))
		else $error("carry changed without cause");

	carry_write_a: assert property (@(posedge clk_sys_i)
		disable iff (!rst_n_i)
		hit && sfr_req_i.wr_en && !alu_flags_i.valid |=>
		carry_flag_o == $past(sfr_req_i.wdata[status_word_pkg::CARRY_BIT]))
		else $error("carry not taken from byte write");

	parity_bit_a: assert property (@(posedge clk_sys_i)
		disable iff (!rst_n_i)
		1'b1 |=>
		status_word_o[status_word_pkg::PARITY_BIT] == ^$past(accumulator_i))
		else $error("parity mismatch");

	parity_write_a: assert property (@(posedge clk_sys_i)
		disable iff (!rst_n_i)
		sw_write |=>
		status_word_o[status_word_pkg::PARITY_BIT] == ^$past(accumulator_i))
		else $error("parity bit taken from software");

endmodule

// ### testbench/tb.sv
// Self-checking testbench for the program status word block
`timescale 1ns/1ps
module tb;
	logic                        clk_sys_i = 1'b0;
	logic                        rst_n_i = 1'b0;
	status_word_pkg::alu_flags_s alu_flags_i = '0;
	status_word_pkg::sfr_req_s   sfr_req_i = '0;
	logic [7:0]                  acc = 8'h00;
	logic [7:0]                  word, rdata, base;
	logic                        carry_flag, nibble_flag, overflow_flag;
	logic [1:0]                  bank;
	int                          err_total = 0;
	int                          n_checks = 0;
	int                          cycles = 0;
	always #2 clk_sys_i = ~clk_sys_i;
	program_status_word_flags uut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
		.alu_flags_i(alu_flags_i), .sfr_req_i(sfr_req_i), .accumulator_i(acc),
		.status_word_o(word), .sfr_rdata_o(rdata),
		.carry_flag_o(carry_flag),
		.nibble_carry_flag_o(nibble_flag),
		.overflow_flag_o(overflow_flag),
		.bank_select_o(bank), .bank_base_o(base));
	task chk(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value at %0t: %h vs %h", $time, seen, exp);
		end
	endtask
	// Inputs move on the falling edge, away from the sampling edge
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_sys_i) sfr_req_i = '{1'b1, 1'b0, a, 3'h0, d, 1'b0};
		@(negedge clk_sys_i) sfr_req_i = '0;
	endtask
	task alu(input logic c, input logic n, input logic o);
		@(negedge clk_sys_i) alu_flags_i = '{1'b1, c, n, o};
		@(negedge clk_sys_i) alu_flags_i = '0;
	endtask
	task bit_wr(input logic [2:0] s, input logic v);
		@(negedge clk_sys_i) sfr_req_i = '{1'b0, 1'b1, 8'hd0, s, 8'h00, v};
		@(negedge clk_sys_i) sfr_req_i = '0;
	endtask
	task test_bank;
		for (int b = 0; b < 4; b++) begin
			wr(8'hd0, 8'(b << 3));
			chk({6'h00, bank}, 8'(b));
			chk(base, 8'(b * 8));
		end
		$display("bank select test done");
	endtask
	task test_flags;
		wr(8'hd0, 8'h22);
		alu(1'b1, 1'b1, 1'b1);
		chk(word, 8'he6);
		chk({5'h00, carry_flag, nibble_flag, overflow_flag}, 8'h07);
		alu(1'b0, 1'b0, 1'b0);
		chk(word, 8'h22);
		chk(rdata, 8'h22);
		chk({7'h00, overflow_flag}, 8'h00);
		// Write to a neighbouring address must leave the word alone
		wr(8'hd1, 8'hff);
		chk(word, 8'h22);
		$display("flag update test done");
	endtask
	task test_parity;
		@(negedge clk_sys_i) acc = 8'h07;
		@(negedge clk_sys_i) chk(word, 8'h23);
		acc = 8'h03;
		@(negedge clk_sys_i) chk(word, 8'h22);
		$display("parity test done");
	endtask
	task test_bits;
		wr(8'hd0, 8'h00);
		bit_wr(3'h5, 1'b1);
		chk(word, 8'h20);
		bit_wr(3'h1, 1'b1);
		chk(word, 8'h22);
		// Parity is even here, so a bit write of one must not stick
		bit_wr(3'h0, 1'b1);
		chk(word, 8'h22);
		bit_wr(3'h4, 1'b1);
		chk({6'h00, bank}, 8'h02);
		chk(base, 8'h10);
		alu(1'b1, 1'b0, 1'b0);
		chk(word, 8'hb2);
		alu(1'b0, 1'b1, 1'b0);
		chk(word, 8'h72);
		chk({5'h00, carry_flag, nibble_flag, overflow_flag}, 8'h02);
		alu(1'b0, 1'b0, 1'b1);
		chk(word, 8'h36);
		chk({5'h00, carry_flag, nibble_flag, overflow_flag}, 8'h01);
		$display("bit write test done");
	endtask
	task test_clash;
		@(negedge clk_sys_i) begin
			sfr_req_i   = '{1'b1, 1'b0, 8'hd0, 3'h0, 8'hff, 1'b0};
			alu_flags_i = '{1'b1, 1'b0, 1'b0, 1'b0};
		end
		@(negedge clk_sys_i) begin
			sfr_req_i   = '0;
			alu_flags_i = '0;
		end
		chk(word, 8'h3a);
		chk(base, 8'h18);
		$display("clash test done");
	endtask
	task conclude;
		$display("checks %0d mismatches %0d", n_checks, err_total);
		if (err_total == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Whole run needs well under a hundred cycles
	always @(posedge clk_sys_i) begin
		cycles++;
		if (cycles == 2000) begin
			err_total++;
			conclude();
		end
	end
	initial begin
		repeat (16) @(negedge clk_sys_i);
		chk(word, 8'h00);
		rst_n_i = 1'b1;
		test_bank();
		test_flags();
		test_parity();
		test_bits();
		test_clash();
		conclude();
	end
endmodule
